// ==== inc/timer_irq_pkg.sv ====
// Package with register map, field layout and constants of the timer channel interrupt block.
// Functional notes
// RULE1 - Enable, disable, mask share one eight-bit layout.
// RULE2 - Enable write sets mask bits written one.
// RULE3 - Disable write clears mask bits written one.
// RULE4 - Mask view reads one per enabled source.
// RULE5 - Overrun and capture loads only in capture mode.
// RULE6 - Compare A and B only in waveform mode.
// RULE7 - Compare C, overflow, trigger in both modes.
// RULE8 - Flags set on event, cleared by status read.
// RULE9 - Waveform select one waveform, zero capture.
// RULE10 - Irq when flag and mask set; masks reset zero.
package timer_irq_pkg;
    localparam int SRC_COUNT = 8;
    localparam int ADDR_W = 8;
    // Byte addresses of the registers.
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_SET = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_MASK_VIEW = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h30;
    // Bit positions of the eight sources.
    localparam int BIT_OVERFLOW = 0;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_COMPARE_A = 2;
    localparam int BIT_COMPARE_B = 3;
    localparam int BIT_COMPARE_C = 4;
    localparam int BIT_LOAD_A = 5;
    localparam int BIT_LOAD_B = 6;
    localparam int BIT_TRIGGER = 7;
    localparam int BIT_WAVE = 0;
    // Sources that apply only in one mode.
    localparam logic [7:0] CAPTURE_ONLY = 8'h62;
    localparam logic [7:0] WAVE_ONLY = 8'h0C;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic WAVE_RESET = 1'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : timer_irq_pkg

// ==== inc/flag_bus_if.sv ====
// Interface carrying status flags and their clear strobe between modules.
`timescale 1ns/1ps
interface flag_bus_if;
    logic [7:0] flags;
    logic clear;
    modport owner (output flags, input clear);
    modport user (input flags, output clear);
endinterface : flag_bus_if

// ==== rtl/status_flags.sv ====
// Sticky status flags, gated by mode, cleared on a status read.
`timescale 1ns/1ps
module status_flags
    import timer_irq_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Events and mode.
    input wire logic [7:0] events,
    input wire logic wave,
    // Flag link.
    flag_bus_if.owner fb
);
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [7:0] allowed;

    // Mode gating and sticky set with the set winning over the read clear.
    always_comb begin
        allowed = 8'hFF;
        if (wave) begin // [RULE9]
            allowed = allowed & ~CAPTURE_ONLY; // [RULE5]
        end else begin
            allowed = allowed & ~WAVE_ONLY; // [RULE6]
        end
        next_flags = fb.clear ? 8'h00 : flags; // [RULE8]
        next_flags = next_flags | (events & allowed); // [RULE7]
    end

    // Flag registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= FLAG_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    assign fb.flags = flags;
endmodule : status_flags

// ==== rtl/timer_channel_irq_mask.sv ====
// Timer channel interrupt mask block with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module timer_channel_irq_mask
    import timer_irq_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Event pulses from the counter logic, same clock.
    input wire logic [7:0] events,
    // Mode and interrupt.
    output logic wave_mode,
    output logic irq
);
    // Flag link to the sticky status flags.
    flag_bus_if fb ();

    // Write channel holding registers and their ready flags.
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready_q;
    logic wready_q;
    logic next_aw_held;
    logic next_w_held;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic do_write;

    // Write response and the software-visible mask and mode.
    logic bvalid;
    logic [1:0] bresp;
    logic [7:0] mask;
    logic wave;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic [7:0] next_mask;
    logic next_wave;

    // Read answer registers and the read address ready flag.
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic arready_q;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_arready;
    logic rd_clear;

    // Registered interrupt level.
    logic irq_q;
    logic next_irq;

    // The register layout holds exactly eight sources in the low byte.
    if (SRC_COUNT != 8) begin : g_src_check
        $error("source count must be eight");
    end
    // The address must reach the highest register offset.
    if (ADDR_W < 6) begin : g_addr_check
        $error("address too narrow for the register map");
    end

    // Sticky flags; the mode gating of the events lives beside them.
    // The flags see the mode register directly, so a mode write acts at once.
    status_flags u_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .events(events),
        .wave(wave),
        .fb(fb)
    );

    // Write channel capture; each channel is taken independently.
    // Address and data may arrive in either order; each is held until
    // both are present and the previous response has been accepted.
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // Both halves held and no response pending: perform the write.
        do_write = aw_held && w_held && !bvalid;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
        end
        // A channel is ready again in the cycle after its word is used.
        next_awready = !next_aw_held;
        next_wready = !next_w_held;
    end

    // Register writes and write response.
    // Enable and disable act only on bits written as one, so software
    // can change single sources without reading the mask first.
    always_comb begin
        next_mask = mask;
        next_wave = wave;
        next_bvalid = bvalid;
        next_bresp = bresp;
        // The response is retired at the edge where bready is seen high.
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            case (aw_addr)
                // Bits written as zero leave their mask bits alone.
                OFS_ENABLE_SET: begin
                    if (w_strb[0]) begin
                        next_mask = mask | w_data[7:0]; // [RULE2] [RULE1]
                    end
                end
                OFS_ENABLE_CLEAR: begin
                    if (w_strb[0]) begin
                        next_mask = mask & ~w_data[7:0]; // [RULE3] [RULE1]
                    end
                end
                OFS_MODE: begin
                    if (w_strb[0]) begin
                        // Only the waveform select bit is kept.
                        next_wave = w_data[BIT_WAVE]; // [RULE9]
                    end
                end
                // Read-only registers take the write and ignore it.
                OFS_STATUS, OFS_MASK_VIEW: begin
                    next_bresp = RESP_OKAY;
                end
                default: begin
                    // Unmapped addresses answer with a slave error.
                    next_bresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // Read channel; a status read clears the flags as it is answered.
    // The flags are cleared at the edge that takes the address, while
    // the answer carries their value from before that edge.
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        rd_clear = 1'b0;
        // The answer is retired at the edge where rready is seen high.
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            case (s_axi_araddr)
                OFS_STATUS: begin
                    next_rdata[7:0] = fb.flags;
                    rd_clear = 1'b1; // [RULE8]
                end
                OFS_MASK_VIEW: begin
                    next_rdata[7:0] = mask; // [RULE4] [RULE1]
                end
                OFS_MODE: begin
                    // Only the waveform select bit is implemented.
                    next_rdata[BIT_WAVE] = wave;
                end
                // Write-only registers read as zero.
                OFS_ENABLE_SET, OFS_ENABLE_CLEAR: begin
                    next_rdata = 32'h0000_0000;
                end
                default: begin
                    // Unmapped addresses answer with a slave error.
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // The read address is refused while an answer is waiting.
    always_comb begin
        next_arready = !next_rvalid;
    end

    // Clear strobe to the flags, one cycle wide.
    assign fb.clear = rd_clear;

    // Interrupt level from flags and masks, registered.
    // A flag whose mask bit is clear stays visible in the status
    // register but never reaches the interrupt line.
    always_comb begin
        next_irq = |(fb.flags & mask); // [RULE10]
    end

    // Every register below resets synchronously; while reset is low the
    // bus shows ready on the request channels and no pending answer, so
    // a request raised at the first edge after release is taken.

    // Write channel registers; the ready flags come straight from flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            awready_q <= next_awready;
            wready_q <= next_wready;
        end
    end

    // Write response, mask and mode registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            mask <= MASK_RESET; // [RULE10]
            wave <= WAVE_RESET;
        end else begin
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            mask <= next_mask;
            wave <= next_wave;
        end
    end

    // Read answer registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
            arready_q <= 1'b1;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            arready_q <= next_arready;
        end
    end

    // Interrupt register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= next_irq;
        end
    end

    // Outputs straight from flip-flops.
    // The ready flags are flops of their own rather than inverted holding
    // flags, so no gate stands between a flop and a pin.
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign wave_mode = wave;
    assign irq = irq_q;
endmodule : timer_channel_irq_mask

// ==== verification/timer_irq_props.sv ====
// Port checks of the timer channel interrupt mask block.
`timescale 1ns/1ps
module timer_irq_props (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Events and outputs.
    input wire logic [7:0] events,
    input wire logic wave_mode,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Handshakes that start a write answer or a read answer.
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Reset values, answer timing and the causes of interrupt changes.
    property p_irq_rst; $rose(aresetn) |-> !irq; endproperty
    property p_mode_rst; $rose(aresetn) |-> !wave_mode; endproperty
    property p_wr; s_wr |=> !s_axi_awready ##1 s_axi_bvalid; endproperty
    property p_rd; s_rd |=> s_axi_rvalid && !s_axi_arready; endproperty
    property p_bh;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rh;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_up; $rose(irq) |-> $past(s_axi_bvalid) || $past(events, 2); endproperty
    property p_dn; $fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_rvalid); endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
    a_mode_rst: assert property (p_mode_rst) else $error("mode reset");
    a_wr: assert property (p_wr) else $error("write answer late");
    a_rd: assert property (p_rd) else $error("read answer late");
    a_bh: assert property (p_bh) else $error("bresp dropped");
    a_rh: assert property (p_rh) else $error("rdata dropped");
    a_up: assert property (p_up) else $error("irq rose alone");
    a_dn: assert property (p_dn) else $error("irq fell alone");
endmodule : timer_irq_props

bind timer_channel_irq_mask timer_irq_props chk_u (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .events, .wave_mode, .irq);

// ==== verification/testbench.sv ====
// Self-checking bench of the timer channel interrupt mask block.
`timescale 1ns/1ps
module testbench
    import timer_irq_pkg::*;
;
    logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, arv = 1'h0;
    logic brd = 1'h0, rrd = 1'h0, awr, wr, bv, arr, rv, wave, irq, w;
    logic [7:0] awa = 8'h00, ara = 8'h00, ev = 8'h00, e, fl, mk = 8'h00;
    logic [31:0] wd = 32'h0, rd, m, c;
    logic [3:0] ws = 4'hF;
    logic [1:0] br, rr;
    logic [33:0] q[$];
    int n_fail = 0, n_checks = 0;
    timer_channel_irq_mask dut_u (.aclk, .aresetn, .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rrd), .events(ev), .wave_mode(wave), .irq);
    // Clock of 25 ns period.
    initial forever #12.5 aclk = ~aclk;
    task automatic chk(input string s, input logic [33:0] v, x);
        n_checks++;
        if (v !== x) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, x, v);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task automatic limit(input int n);
        if (n < 100) return;
        n_fail++;
        wrap_up();
    endtask : limit
    // Write with address and data offered together.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r);
        int n;
        q.push_back({r, 32'h0});
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'h0;
            if (wv && wr) wv <= 1'h0;
            n++;
        end while (n < 100 && !(bv && brd));
        limit(n);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] x,
        input logic [1:0] r = RESP_OKAY);
        int n;
        q.push_back({r, 24'h0, x});
        ara <= a;
        arv <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'h0;
            n++;
        end while (n < 100 && !(rv && rrd));
        limit(n);
    endtask : rd_reg
    // Answers are compared with the oldest note; ready stalls at random.
    always @(posedge aclk) begin
        if (rv && rrd) chk("read", {rr, rd}, q.pop_front());
        if (bv && brd) chk("bresp", {br, 32'h0}, q.pop_front());
        rrd <= rrd ? !rv : 1'($urandom_range(1));
        brd <= brd ? !bv : 1'($urandom_range(1));
    end
    // Reset, register checks, then random modes, masks and events.
    initial begin
        void'($urandom(32'h4A9AB1A2));
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd_reg(OFS_MASK_VIEW, 8'h00);
        rd_reg(OFS_ENABLE_SET, 8'h00);
        wr_reg(8'h3C, 32'hFF, RESP_SLVERR);
        ws <= 4'hE;
        wr_reg(OFS_ENABLE_SET, 32'hFF, RESP_OKAY);
        ws <= 4'hF;
        rd_reg(OFS_MASK_VIEW, 8'h00);
        for (int i = 0; i < 16; i++) begin
            w = 1'($urandom_range(1));
            m = $urandom;
            c = $urandom;
            e = 8'($urandom);
            wr_reg(OFS_MODE, {31'h0, w}, RESP_OKAY);
            rd_reg(OFS_MODE, {7'h00, w});
            chk("wave_mode", {33'h0, wave}, {33'h0, w});
            wr_reg(OFS_ENABLE_SET, m, RESP_OKAY);
            wr_reg(OFS_ENABLE_CLEAR, c, RESP_OKAY);
            mk = (mk | m[7:0]) & ~c[7:0];
            rd_reg(OFS_MASK_VIEW, mk);
            ev <= e;
            @(posedge aclk);
            ev <= 8'h00;
            repeat (3) @(posedge aclk);
            fl = e & ~(w ? CAPTURE_ONLY : WAVE_ONLY);
            chk("irq", {33'h0, irq}, {33'h0, |(fl & mk)});
            rd_reg(OFS_STATUS, fl);
            rd_reg(OFS_STATUS, 8'h00);
            @(posedge aclk);
            chk("irq", {33'h0, irq}, 34'h0);
        end
        // Unmapped read, then an event at the edge that takes a status read.
        rd_reg(8'h3C, 8'h00, RESP_SLVERR);
        fork
            rd_reg(OFS_STATUS, 8'h00);
            begin
                ev <= 8'h10;
                @(posedge aclk);
                ev <= 8'h00;
            end
        join
        rd_reg(OFS_STATUS, 8'h10);
        // Mask, mode and a pending interrupt, then a reset in mid-run.
        wr_reg(OFS_MODE, 32'h1, RESP_OKAY);
        wr_reg(OFS_ENABLE_SET, 32'hFF, RESP_OKAY);
        ev <= 8'h80;
        @(posedge aclk);
        ev <= 8'h00;
        repeat (2) @(posedge aclk);
        chk("irq", {33'h0, irq}, 34'h1);
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("irq", {33'h0, irq}, 34'h0);
        rd_reg(OFS_MASK_VIEW, 8'h00);
        rd_reg(OFS_STATUS, 8'h00);
        rd_reg(OFS_MODE, 8'h00);
        wrap_up();
    end
endmodule : testbench
